// [hw/bus_matrix.sv]
// Multi-layer switch fabric: per-master decoders, per-slave arbiters and the register file.
`include "matrix_cfg.svh"

module bus_matrix
    import matrix_pkg::*;
#(
    parameter int NUM_MASTERS = 7,
    parameter int NUM_SLAVES  = 10,
    localparam int OWNER_W    = $clog2(NUM_MASTERS)
)
(
    input  wire logic                                 hclk,
    input  wire logic                                 hresetn,
    input  wire logic                                 hsel,
    input  wire logic [31:0]                          haddr,
    input  wire logic [1:0]                           htrans,
    input  wire logic                                 hwrite,
    input  wire logic [2:0]                           hsize,
    input  wire logic [31:0]                          hwdata,
    input  wire logic                                 hready,
    output logic      [31:0]                          hrdata,
    output logic                                      hreadyout,
    output logic                                      hresp,
    input  master_req_t [NUM_MASTERS-1:0]             master_req,
    input  wire logic [NUM_SLAVES-1:0]                slave_ready,
    output logic      [NUM_MASTERS-1:0]               master_grant,
    output logic      [NUM_MASTERS-1:0]               master_error,
    output logic      [NUM_SLAVES-1:0]                slave_connected,
    output logic      [NUM_SLAVES-1:0][OWNER_W-1:0]   slave_owner
);

    typedef struct packed
    {
        bus_phase_t                               phase;
        logic [11:0]                              addr;
        logic                                     hreadyout;
        logic [31:0]                              hrdata;
        logic [15:0][31:0]                        burst_cfg;
        logic [15:0][31:0]                        arb_cfg;
        logic [15:0][31:0]                        prio_lo;
        logic [15:0][31:0]                        prio_hi;
        logic [15:0][31:0]                        spare;
        logic [NUM_SLAVES-1:0][OWNER_W-1:0]       owner;
        logic [NUM_SLAVES-1:0]                    connected;
        logic [NUM_SLAVES-1:0][4:0]               beats;
        logic [NUM_SLAVES-1:0][`SLOT_W-1:0]       slot;
        logic [NUM_MASTERS-1:0]                   grant;
        logic [NUM_MASTERS-1:0]                   error;
    } state_t;
    state_t st;
    state_t next_st;
    logic [NUM_SLAVES-1:0][NUM_MASTERS-1:0] req_mask;
    logic [NUM_SLAVES-1:0]                  beat_done;
    logic [NUM_SLAVES-1:0]                  rearb;
    logic [NUM_SLAVES-1:0]                  slot_hit;

    // master 1, the instruction port, sees a narrower map than the others.
    function automatic logic reachable(input int m, input int s);
        logic [15:0] blocked;
        blocked = `INSTR_BLOCKED;
        reachable = (s < NUM_SLAVES) && !((m == int'(`INSTR_MASTER)) && blocked[s]);
    endfunction

    // the top address nibble is the slave index; hit low means nothing answers.
    function automatic logic [4:0] decode(input int m, input logic [31:0] a);
        logic [3:0] s;
        s = a[`SLAVE_SEL_MSB:`SLAVE_SEL_LSB];
        decode = {reachable(m, int'(s)), s};
    endfunction

    function automatic logic [`PRIO_W-1:0] prio_of(input logic [31:0] lo, input logic [31:0] hi, input int m);
        if (m < `PRIO_PER_REG)
            prio_of = lo[m * `PRIO_STRIDE +: `PRIO_W];
        else
            prio_of = hi[(m - `PRIO_PER_REG) * `PRIO_STRIDE +: `PRIO_W];
    endfunction

    // scan starts after the last owner; a tie keeps the earliest in rotation.
    function automatic logic [OWNER_W:0] pick(input logic [NUM_MASTERS-1:0] req, input logic fixedp,
                                              input logic [31:0] lo, input logic [31:0] hi,
                                              input logic [OWNER_W-1:0] last);
        logic               found;
        logic [OWNER_W-1:0] win;
        logic [`PRIO_W-1:0] best;
        logic [`PRIO_W-1:0] p;
        int                 idx;
        found = 1'b0;
        win   = '0;
        best  = '0;
        for (int k = 1; k <= NUM_MASTERS; k++)
        begin
            idx = (int'(last) + k) % NUM_MASTERS;
            // round-robin treats every requester as equal.
            p = fixedp ? prio_of(lo, hi, idx) : '0;
            if (req[idx] && (!found || p > best))
            begin
                found = 1'b1;
                win   = OWNER_W'(idx);
                best  = p;
            end
        end
        pick = {found, win};
    endfunction

    function automatic logic [31:0] reg_read(input state_t s, input logic [11:0] a);
        reg_read = '0;
        if (a < `ARB_CFG_BASE)
            reg_read = s.burst_cfg[a[5:2]];
        else if (a < `PRIO_BASE)
            reg_read = s.arb_cfg[a[5:2]];
        else if (a < `PRIO_END)
            reg_read = a[2] ? s.prio_hi[a[6:3]] : s.prio_lo[a[6:3]];
        else if (a >= `SPARE_BASE && a < `SPARE_END)
            reg_read = s.spare[4'((a - `SPARE_BASE) >> 2)];
    endfunction

    always_comb
    begin
        logic [4:0]               dec;
        logic [OWNER_W-1:0]       cur;
        logic [31:0]              cfg;
        logic [`SPLIT_W-1:0]      split;
        logic [4:0]               beats_inc;
        logic                     boundary;
        logic [OWNER_W:0]         won;
        logic [OWNER_W-1:0]       fixed;
        logic [11:0]              a;
        dec       = '0;
        cur       = '0;
        cfg       = '0;
        split     = '0;
        beats_inc = '0;
        boundary  = 1'b0;
        won       = '0;
        fixed     = '0;
        a         = st.addr;
        next_st   = st;
        req_mask  = '0;
        beat_done = '0;
        rearb     = '0;
        slot_hit  = '0;
        // Register bus: writes are zero-wait, reads take one wait state.
        // The wait state lets a read that follows a write see the new value.
        unique case (st.phase)
            bus_write:
            begin
                if (a < `ARB_CFG_BASE)
                    next_st.burst_cfg[a[5:2]] = hwdata & `BURST_CFG_MASK;
                else if (a < `PRIO_BASE)
                    next_st.arb_cfg[a[5:2]] = hwdata & `ARB_CFG_MASK;
                // low and high priority words alternate per slave.
                else if (a < `PRIO_END && a[2])
                    next_st.prio_hi[a[6:3]] = hwdata & `PRIO_MASK;
                else if (a < `PRIO_END)
                    next_st.prio_lo[a[6:3]] = hwdata & `PRIO_MASK;
                else if (a >= `SPARE_BASE && a < `SPARE_END)
                    next_st.spare[4'((a - `SPARE_BASE) >> 2)] = hwdata;
                next_st.phase = bus_idle;
            end
            bus_read_wait:
            begin
                next_st.hrdata    = reg_read(st, a);
                next_st.hreadyout = 1'b1;
                next_st.phase     = bus_idle;
            end
            bus_idle:      next_st.phase = bus_idle;
        endcase
        if (hsel && htrans[1] && hready && st.hreadyout)
        begin
            next_st.addr = {haddr[11:2], 2'b00};
            if (hwrite)
                next_st.phase = bus_write;
            else
            begin
                next_st.phase     = bus_read_wait;
                next_st.hreadyout = 1'b0;
            end
        end
        for (int m = 0; m < NUM_MASTERS; m++)
        begin
            dec = decode(m, master_req[m].addr);
            // unmapped or unreachable address answers with an error.
            next_st.error[m] = master_req[m].valid && !dec[4];
            for (int s = 0; s < NUM_SLAVES; s++)
                req_mask[s][m] = master_req[m].valid && dec[4] && (int'(dec[3:0]) == s);
        end
        // every slave has its own arbiter and configuration word.
        for (int s = 0; s < NUM_SLAVES; s++)
        begin
            cur          = st.owner[s];
            cfg          = st.arb_cfg[s];
            split        = st.burst_cfg[cur][`SPLIT_LSB +: `SPLIT_W];
            beat_done[s] = st.connected[s] && req_mask[s][cur] && slave_ready[s];
            beats_inc    = st.beats[s] + 5'h01;
            // setting 0 never yields a chunk end.
            // setting 1 ends a chunk on every beat.
            // settings 2 to 4 end after 4, 8 or 16 beats.
            unique case (split)
                `SPLIT_SINGLE:  boundary = 1'b1;
                `SPLIT_FOUR:    boundary = (beats_inc == `CHUNK_FOUR);
                `SPLIT_EIGHT:   boundary = (beats_inc == `CHUNK_EIGHT);
                `SPLIT_SIXTEEN: boundary = (beats_inc == `CHUNK_SIXTEEN);
                default:        boundary = 1'b0;
            endcase
            // the slot limit makes a long burst breakable.
            slot_hit[s] = (cfg[`SLOT_LSB +: `SLOT_W] != '0) && (st.slot[s] >= cfg[`SLOT_LSB +: `SLOT_W]);
            // switch only between beats, never while a beat is pending.
            rearb[s] = !st.connected[s] || !req_mask[s][cur] ||
                       (beat_done[s] && (!master_req[cur].incr || boundary || slot_hit[s]));
            if (rearb[s])
            begin
                won = pick(req_mask[s], cfg[`ARB_POLICY_BIT], st.prio_lo[s], st.prio_hi[s], cur);
                next_st.beats[s] = '0;
                next_st.slot[s]  = '0;
                fixed = cfg[`FIXED_OWNER_LSB +: OWNER_W];
                if (won[OWNER_W])
                begin
                    next_st.owner[s]     = won[OWNER_W-1:0];
                    next_st.connected[s] = 1'b1;
                end
                else if (cfg[`IDLE_POLICY_LSB +: `IDLE_POLICY_W] == `IDLE_KEEP_LAST)
                    next_st.connected[s] = st.connected[s];
                // an unreachable fixed owner falls back to disconnecting.
                else if (cfg[`IDLE_POLICY_LSB +: `IDLE_POLICY_W] == `IDLE_FIXED &&
                         int'(fixed) < NUM_MASTERS && reachable(int'(fixed), s))
                begin
                    next_st.owner[s]     = fixed;
                    next_st.connected[s] = 1'b1;
                end
                // disconnected; a new request waits one cycle for its grant.
                else
                    next_st.connected[s] = 1'b0;
            end
            else
            begin
                if (beat_done[s])
                    next_st.beats[s] = beats_inc;
                if (st.slot[s] != '1)
                    next_st.slot[s] = st.slot[s] + `SLOT_W'(1);
            end
        end

        for (int m = 0; m < NUM_MASTERS; m++)
        begin
            next_st.grant[m] = 1'b0;
            for (int s = 0; s < NUM_SLAVES; s++)
                if (next_st.connected[s] && int'(next_st.owner[s]) == m && req_mask[s][m])
                    next_st.grant[m] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st           <= '0;
            st.hreadyout <= 1'b1;
            st.burst_cfg <= {16{`BURST_CFG_RESET}};
            st.arb_cfg   <= {16{`ARB_CFG_RESET}};
            st.prio_lo   <= {16{`PRIO_RESET}};
            st.prio_hi   <= {16{`PRIO_RESET}};
            st.spare     <= {16{`SPARE_RESET}};
        end
        else
            st <= next_st;
    end

    assign hrdata          = st.hrdata;
    assign hreadyout       = st.hreadyout;
    assign hresp           = 1'b0;
    assign master_grant    = st.grant;
    assign master_error    = st.error;
    assign slave_connected = st.connected;
    assign slave_owner     = st.owner;

    // Checks on slave 0 and master 0; every slave runs the same logic.
    logic [`SPLIT_W-1:0] s0_split;
    logic [1:0]          s0_policy;
    logic                s0_rr;
    logic                s0_other;
    assign s0_split  = st.burst_cfg[st.owner[0]][`SPLIT_LSB +: `SPLIT_W];
    assign s0_policy = st.arb_cfg[0][`IDLE_POLICY_LSB +: `IDLE_POLICY_W];
    assign s0_rr     = !st.arb_cfg[0][`ARB_POLICY_BIT];
    assign s0_other  = (req_mask[0] & ~(NUM_MASTERS'(1) << st.owner[0])) != '0;

    // no break without the slot limit
    split_none_a: assert property (@(posedge hclk) disable iff (!hresetn)
        beat_done[0] && s0_split == `SPLIT_NONE && master_req[st.owner[0]].incr && !slot_hit[0]
        |=> st.connected[0] && st.owner[0] == $past(st.owner[0]))
        else $error("unbreakable burst lost its slave");
    split_single_a: assert property (@(posedge hclk) disable iff (!hresetn)
        beat_done[0] && s0_split == `SPLIT_SINGLE && s0_rr && s0_other
        |=> st.owner[0] != $past(st.owner[0]))
        else $error("single-beat split did not re-arbitrate");
    split_four_a: assert property (@(posedge hclk) disable iff (!hresetn)
        beat_done[0] && s0_split == `SPLIT_FOUR && st.beats[0] == 5'h03 && s0_rr && s0_other
        |=> st.owner[0] != $past(st.owner[0]) && st.beats[0] == 5'h00)
        else $error("four-beat chunk did not end");
    idle_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        req_mask[0] == '0 && s0_policy == `IDLE_DISCONNECT |=> !slave_connected[0])
        else $error("idle slave stayed connected");
    idle_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        req_mask[0] == '0 && s0_policy == `IDLE_KEEP_LAST && st.connected[0]
        |=> slave_connected[0] && $stable(slave_owner[0]))
        else $error("idle slave left its last master");
    idle_fixed_a: assert property (@(posedge hclk) disable iff (!hresetn)
        req_mask[0] == '0 && s0_policy == `IDLE_FIXED &&
        int'(st.arb_cfg[0][`FIXED_OWNER_LSB +: OWNER_W]) < NUM_MASTERS
        |=> slave_connected[0] && slave_owner[0] == $past(st.arb_cfg[0][`FIXED_OWNER_LSB +: OWNER_W]))
        else $error("idle slave not parked on fixed owner");
    bad_fixed_a: assert property (@(posedge hclk) disable iff (!hresetn)
        req_mask[0] == '0 && s0_policy == `IDLE_FIXED &&
        int'(st.arb_cfg[0][`FIXED_OWNER_LSB +: OWNER_W]) >= NUM_MASTERS |=> !slave_connected[0])
        else $error("invalid fixed owner kept slave connected");
    slot_break_a: assert property (@(posedge hclk) disable iff (!hresetn)
        beat_done[0] && slot_hit[0] && s0_rr && s0_other |=> st.owner[0] != $past(st.owner[0]))
        else $error("slot limit did not break the burst");
    unmapped_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
        master_req[0].valid && int'(master_req[0].addr[`SLAVE_SEL_MSB:`SLAVE_SEL_LSB]) >= NUM_SLAVES
        |=> master_error[0] && !master_grant[0])
        else $error("unmapped access not flagged");
    // Register reads answer after exactly one wait state.
    read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hsel && htrans[1] && hready && hreadyout && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    handover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        beat_done[0] && s0_other ##1 $changed(slave_owner[0]));
    park_c: cover property (@(posedge hclk) disable iff (!hresetn)
        s0_policy == `IDLE_FIXED && req_mask[0] == '0 ##1 slave_connected[0]);
    unmapped_c: cover property (@(posedge hclk) disable iff (!hresetn) master_error[0]);

endmodule

// [hw/matrix_cfg.svh]
// Register map, field layout, reset values and memory map constants of the switch fabric.
`ifndef MATRIX_CFG_SVH
`define MATRIX_CFG_SVH

`define BURST_CFG_BASE      12'h000
`define ARB_CFG_BASE        12'h040
`define PRIO_BASE           12'h080
`define PRIO_END            12'h100
`define SPARE_BASE          12'h110
`define SPARE_END           12'h150

`define BURST_CFG_RESET     32'h00000002
`define BURST_CFG_MASK      32'h00000007
`define ARB_CFG_RESET       32'h00000010
`define ARB_CFG_MASK        32'h011f00ff
`define PRIO_RESET          32'h00000000
`define PRIO_MASK           32'h33333333
`define SPARE_RESET         32'h00000000

`define SPLIT_LSB           0
`define SPLIT_W             3
`define SLOT_LSB            0
`define SLOT_W              8
`define IDLE_POLICY_LSB     16
`define IDLE_POLICY_W       2
`define FIXED_OWNER_LSB     18
`define ARB_POLICY_BIT      24
`define PRIO_W              2
`define PRIO_STRIDE         4
`define PRIO_PER_REG        8

`define SPLIT_NONE          3'h0
`define SPLIT_SINGLE        3'h1
`define SPLIT_FOUR          3'h2
`define SPLIT_EIGHT         3'h3
`define SPLIT_SIXTEEN       3'h4
`define CHUNK_FOUR          5'h04
`define CHUNK_EIGHT         5'h08
`define CHUNK_SIXTEEN       5'h10

`define IDLE_DISCONNECT     2'h0
`define IDLE_KEEP_LAST      2'h1
`define IDLE_FIXED          2'h2

`define SLAVE_SEL_MSB       31
`define SLAVE_SEL_LSB       28
`define INSTR_MASTER        3'h1
`define INSTR_BLOCKED       16'h008e

`endif

// [hw/matrix_pkg.sv]
// Types shared by the switch fabric and its surroundings.
package matrix_pkg;

    typedef struct packed
    {
        logic        valid;
        logic [31:0] addr;
        logic        incr;
    } master_req_t;

    typedef enum logic [1:0] {bus_idle, bus_write, bus_read_wait} bus_phase_t;

endpackage

// [verif/slave_model.sv]
// Model of the slaves behind the fabric: each answers beats at once or with random stalls.
module slave_model
#(
    parameter int NUM_SLAVES = 10
)
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  slow,
    output logic      [NUM_SLAVES-1:0] slave_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 34;

    // A stalling slave must not hold up arbitration, so stalls are drawn afresh every cycle.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            slave_ready <= '0;
        else if (slow)
            slave_ready <= NUM_SLAVES'($random(seed));
        else
            slave_ready <= '1;
    end
endmodule

// [verif/tb.sv]
// Self-checking bench for the switch fabric: registers, arbitration, idle owners and random traffic.
module tb
    import matrix_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, rd, d;
    logic [1:0]        htrans = 2'h0;
    logic [2:0]        hsize = 3'h2;
    logic              hreadyout, hresp;
    logic [9:0]        rdy, conn;
    logic [6:0]        grant, merr;
    logic [9:0][2:0]   owner;
    master_req_t [6:0] mreq = '0, prev = '0;
    int                error_cnt = 0, num_checks = 0, seed = 34, cyc = 0, n;
    logic [11:0]       addrs [10] = '{12'h000, 12'h018, 12'h044, 12'h064, 12'h080,
                                      12'h0cc, 12'h110, 12'h14c, 12'h150, 12'h200};

    bus_matrix dut_u
    (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .hsel           (hsel),
        .haddr          (haddr),
        .htrans         (htrans),
        .hwrite         (hwrite),
        .hsize          (hsize),
        .hwdata         (hwdata),
        .hready         (hreadyout),
        .hrdata         (hrdata),
        .hreadyout      (hreadyout),
        .hresp          (hresp),
        .master_req     (mreq),
        .slave_ready    (rdy),
        .master_grant   (grant),
        .master_error   (merr),
        .slave_connected(conn),
        .slave_owner    (owner)
    );

    slave_model far_u
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .slow       (slow),
        .slave_ready(rdy)
    );

    initial
        forever #20 hclk = ~hclk;

    function automatic logic [31:0] rst_of(input logic [11:0] a);
        return a < 12'h040 ? 32'h00000002 : a < 12'h080 ? 32'h00000010 : 32'h00000000;
    endfunction

    // Reserved bits read as zero; holes in the map read zero and ignore writes.
    function automatic logic [31:0] mask_of(input logic [11:0] a);
        return a < 12'h040 ? 32'h00000007 : a < 12'h080 ? 32'h011f00ff : a < 12'h100 ? 32'h33333333 :
               (a >= 12'h110 && a < 12'h150) ? 32'hffffffff : 32'h00000000;
    endfunction

    task automatic chk(input bit ok, input string msg);
        num_checks++;
        if (!ok)
        begin
            error_cnt++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp === 1'b0, "bus response");
    endtask

    task automatic req(input int m, input logic v, input int s, input logic inc);
        mreq[m] <= '{v, {4'(s), 28'h0}, inc};
    endtask

    // Waits for slave s to be connected (c) to master m; n gives the cycles waited.
    task automatic own(input int s, input logic [2:0] m, input logic c, output int w);
        w = 0;
        while (!(conn[s] === c && (!c || owner[s] === m)) && w < 60)
        begin
            @(posedge hclk);
            w++;
        end
        chk(w < 60, "slave owner");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end

    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (addrs[i])
        begin
            bus(addrs[i], 1'b0, 32'h0);
            chk(rd === rst_of(addrs[i]), "reset value");
            d = $random(seed);
            bus(addrs[i], 1'b1, d);
            bus(addrs[i], 1'b0, 32'h0);
            chk(rd === (d & mask_of(addrs[i])), "read back");
        end
        $display("test registers done");
        bus(12'h040, 1'b1, 32'h0);
        bus(12'h000, 1'b1, 32'h0);
        req(0, 1'b1, 0, 1'b1);
        own(0, 3'h0, 1'b1, n);
        req(2, 1'b1, 0, 1'b1);
        repeat (20)
        begin
            @(posedge hclk);
            chk(owner[0] === 3'h0, "unbroken burst");
        end
        bus(12'h000, 1'b1, 32'h1);
        own(0, 3'h2, 1'b1, n);
        for (int k = 2; k < 5; k++)
        begin
            bus(12'h008, 1'b1, 32'(k));
            own(0, 3'h0, 1'b1, n);
            own(0, 3'h2, 1'b1, n);
            own(0, 3'h0, 1'b1, n);
            chk(n == (1 << k), "chunk length");
        end
        bus(12'h008, 1'b1, 32'h0);
        bus(12'h040, 1'b1, 32'h10);
        // The burst running while the limit was written began early, so time a fresh one.
        own(0, 3'h0, 1'b1, n);
        own(0, 3'h2, 1'b1, n);
        own(0, 3'h0, 1'b1, n);
        chk(n >= 16 && n <= 17, "slot limit");
        $display("test bursts done");
        bus(12'h050, 1'b1, 32'h01000000);
        bus(12'h0a0, 1'b1, 32'h00000300);
        req(0, 1'b1, 4, 1'b0);
        req(2, 1'b1, 4, 1'b0);
        own(4, 3'h2, 1'b1, n);
        repeat (10)
        begin
            @(posedge hclk);
            chk(owner[4] === 3'h2, "fixed priority");
            chk(grant === 7'h04, "grant flags");
        end
        bus(12'h050, 1'b1, 32'h0);
        own(4, 3'h0, 1'b1, n);
        req(0, 1'b0, 4, 1'b0);
        req(2, 1'b0, 0, 1'b0);
        own(4, 3'h0, 1'b0, n);
        // Idle owner policies run on slave 0, where the fabric's own checks watch.
        bus(12'h040, 1'b1, 32'h00010000);
        req(2, 1'b1, 0, 1'b0);
        own(0, 3'h2, 1'b1, n);
        req(2, 1'b0, 0, 1'b0);
        repeat (5)
        begin
            @(posedge hclk);
            chk(conn[0] === 1'b1 && owner[0] === 3'h2, "keep last owner");
        end
        bus(12'h040, 1'b1, 32'h00160000);
        own(0, 3'h5, 1'b1, n);
        bus(12'h040, 1'b1, 32'h001e0000);
        own(0, 3'h0, 1'b0, n);
        $display("test arbitration done");
        slow <= 1'b1;
        prev = mreq;
        repeat (400)
        begin
            @(posedge hclk);
            for (int m = 0; m < 7; m++)
            begin
                chk(merr[m] === (prev[m].valid && prev[m].addr[31:28] > 4'h9), "error flag");
                chk(!(grant[m] === 1'b1 && prev[m].addr[31:28] > 4'h9), "unmapped grant");
                if (!mreq[m].valid || (merr[m] && mreq[m].addr[31:28] > 4'h9) || (grant[m] && rdy[mreq[m].addr[31:28]]))
                    req(m, 1'($random(seed)), m == 1 ? 0 : $unsigned($random(seed)) % 12, 1'($random(seed)));
            end
            prev = mreq;
        end
        $display("test random traffic done");
        conclude();
    end
endmodule
